// ==== sfr_cfg.svh ====
// Purpose: constants for the synth filter and readback register block
// Assumes: core clock 10 MHz, master clock enable 1 MHz
// Notes: offsets are register indices on the 5-bit address pins
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH
`define SFR_CLK_HZ 10000000
`define SFR_MCLK_HZ 1000000
`define SFR_TICK_DIV (`SFR_CLK_HZ / `SFR_MCLK_HZ)
`define SFR_NUM_RW 25
`define SFR_GROUP 7
`define SFR_V_FREQ_LO 0
`define SFR_V_FREQ_HI 1
`define SFR_V_PW_LO 2
`define SFR_V_PW_HI 3
`define SFR_V_CTRL 4
`define SFR_V_AD 5
`define SFR_V_SR 6
`define SFR_A_CUT_LO 5'h15
`define SFR_A_CUT_HI 5'h16
`define SFR_A_ROUTE 5'h17
`define SFR_A_RESP 5'h18
`define SFR_A_PADX 5'h19
`define SFR_A_PADY 5'h1A
`define SFR_A_OSC3 5'h1B
`define SFR_A_ENV3 5'h1C
`define SFR_CB_GATE 0
`define SFR_CB_SYNC 1
`define SFR_CB_RING 2
`define SFR_CB_TEST 3
`define SFR_CB_TRI 4
`define SFR_CB_SAW 5
`define SFR_CB_PUL 6
`define SFR_CB_NOI 7
`define SFR_RB_V3_OFF 7
`define SFR_PAD_LAST 9'h1FF
`define SFR_PAD_MAX 8'hFF
`define SFR_ENV_SHIFT 3
`endif

// ==== sfr_host.sv ====
// Purpose: host processor model on the synth register pins
// Assumes: pins change just after the falling core edge
// Notes: write data shows its inverse once released
`timescale 1ns/1ps
module sfr_host (
  input wire logic core_clk,
  output logic bus_phase,
  output logic cs_n,
  output logic rw,
  output logic [4:0] addr,
  output logic [7:0] host_data,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n
);
  initial
  begin
    bus_phase = 1'b0;
    cs_n = 1'b1;
    rw = 1'b1;
    addr = 5'h00;
    host_data = 8'h00;
  end

  task automatic cycle(input logic [4:0] a, input logic [7:0] d, input logic rd,
    input logic sel_n, output logic [7:0] q, output logic oe_n);
    @(negedge core_clk);
    addr = a;
    rw = rd;
    cs_n = sel_n;
    host_data = rd ? ~d : d;
    bus_phase = 1'b1;
    repeat (5) @(negedge core_clk);
    q = data_out;
    oe_n = data_oe_n;
    bus_phase = 1'b0;
    repeat (5) @(negedge core_clk);
    cs_n = 1'b1;
    rw = 1'b1;
    host_data = ~host_data;
  endtask : cycle
endmodule : sfr_host

// ==== sfr_pkg.sv ====
// Purpose: shared types of the synth register block
// Assumes: nothing
// Notes: constants live in sfr_cfg.svh
package sfr_pkg;
  typedef enum logic [1:0] {ENV_ATTACK, ENV_DECAY, ENV_SUSTAIN, ENV_RELEASE} sfr_env_t;
  typedef logic [7:0] sfr_byte_t;
endpackage : sfr_pkg

// ==== sfr_regs.sv ====
// Purpose: synth register bank, mixer control and readback
// Assumes: bus pins asynchronous to core_clk, sampled through two flops
// Notes: writes commit at the falling edge of the bus clock phase
`timescale 1ns/1ps
`include "sfr_cfg.svh"
module sfr_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic chip_reset_n,
  input wire logic bus_phase,
  input wire logic cs_n,
  input wire logic rw,
  input wire logic [4:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic paddle_x_in,
  input wire logic paddle_y_in,
  output logic paddle_dump_out,
  output logic paddle_dump_oe_n,
  input wire logic [7:0] ext_in,
  output logic [13:0] audio_direct,
  output logic [9:0] filter_input,
  output logic [10:0] cutoff_value,
  output logic [3:0] peak_emphasis,
  output logic lowpass_select,
  output logic bandpass_select,
  output logic upper_band_select,
  output logic [3:0] master_level
);
  // -----------------------------------------------------------------
  // reset and pin synchronisers
  // -----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_s_n;
  logic [18:0] pin_s1_reg, pin_s2_reg;
  logic ph_s, cs_s, rw_s, chip_clr;
  logic [4:0] addr_s;
  logic [7:0] data_s;
  logic [1:0] pad_s;
  logic ph_p_reg, cs_p_reg, rw_p_reg;
  logic [4:0] addr_p_reg;
  logic [7:0] data_p_reg;

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  assign rst_s_n = rst_sync_reg[1];

  always_ff @(posedge core_clk or negedge rst_s_n)
    if (!rst_s_n)
    begin
      pin_s1_reg <= 19'h7FFFF;
      pin_s2_reg <= 19'h7FFFF;
    end
    else
    begin
      pin_s1_reg <= {bus_phase, cs_n, rw, addr, data_in, chip_reset_n,
                     paddle_y_in, paddle_x_in};
      pin_s2_reg <= pin_s1_reg;
    end
  assign {ph_s, cs_s, rw_s, addr_s, data_s} = pin_s2_reg[18:3];
  assign pad_s = pin_s2_reg[1:0];
  assign chip_clr = ~pin_s2_reg[2];

  always_ff @(posedge core_clk or negedge rst_s_n)
    if (!rst_s_n)
    begin
      ph_p_reg <= 1'b0;
      cs_p_reg <= 1'b1;
      rw_p_reg <= 1'b1;
      addr_p_reg <= 5'h00;
      data_p_reg <= 8'h00;
    end
    else
    begin
      ph_p_reg <= ph_s;
      cs_p_reg <= cs_s;
      rw_p_reg <= rw_s;
      addr_p_reg <= addr_s;
      data_p_reg <= data_s;
    end

  // -----------------------------------------------------------------
  // master clock enable
  // -----------------------------------------------------------------
  logic [3:0] div_reg;
  logic tick;
  assign tick = (div_reg == 4'(`SFR_TICK_DIV - 1));
  always_ff @(posedge core_clk or negedge rst_s_n)
    if (!rst_s_n)
      div_reg <= 4'h0;
    else
      div_reg <= tick ? 4'h0 : div_reg + 4'h1;

  // -----------------------------------------------------------------
  // register file and bus
  // -----------------------------------------------------------------
  sfr_pkg::sfr_byte_t rw_regs [0:`SFR_NUM_RW-1];
  sfr_pkg::sfr_byte_t pad_regs [0:1];
  logic wr_stb, rd_sel;
  logic [11:0] wave3;
  sfr_pkg::sfr_byte_t env3, rd_mux, data_out_reg;

  // write on phase falling edge, select low
  assign wr_stb = ph_p_reg & ~ph_s & ~cs_p_reg & ~rw_p_reg;
  assign rd_sel = ph_s & ~cs_s & rw_s;
  assign data_oe_n = ~rd_sel;
  assign data_out = data_out_reg;

  always_ff @(posedge core_clk or negedge rst_s_n)
    if (!rst_s_n)
    begin
      for (int k = 0; k < `SFR_NUM_RW; k++)
        rw_regs[k] <= 8'h00;
    end
    else if (chip_clr)
    begin
      for (int k = 0; k < `SFR_NUM_RW; k++)
        rw_regs[k] <= 8'h00;
    end
    else if (wr_stb && addr_p_reg < 5'(`SFR_NUM_RW))
      rw_regs[addr_p_reg] <= data_p_reg;

  assign rd_mux = (addr_s == `SFR_A_PADX) ? pad_regs[0]
    : (addr_s == `SFR_A_PADY) ? pad_regs[1]
    : (addr_s == `SFR_A_OSC3) ? wave3[11:4]
    : (addr_s == `SFR_A_ENV3) ? env3 : 8'h00;

  always_ff @(posedge core_clk or negedge rst_s_n)
    if (!rst_s_n)
      data_out_reg <= 8'h00;
    else
      data_out_reg <= rd_mux;

  // -----------------------------------------------------------------
  // voices
  // -----------------------------------------------------------------
  sfr_voice_if vif [3] ();
  sfr_pkg::sfr_byte_t amp [0:2];
  logic [15:0] prod [0:2];

  genvar gv;
  generate
    for (gv = 0; gv < 3; gv++)
    begin : g_voice
      localparam int B = gv * `SFR_GROUP;
      assign vif[gv].freq = {rw_regs[B + `SFR_V_FREQ_HI], rw_regs[B + `SFR_V_FREQ_LO]};
      assign vif[gv].pw = {rw_regs[B + `SFR_V_PW_HI][3:0], rw_regs[B + `SFR_V_PW_LO]};
      assign vif[gv].ctrl = rw_regs[B + `SFR_V_CTRL];
      assign vif[gv].ad = rw_regs[B + `SFR_V_AD];
      assign vif[gv].sr = rw_regs[B + `SFR_V_SR];
      assign prod[gv] = vif[gv].wave[11:4] * vif[gv].env;
      assign amp[gv] = prod[gv][15:8];
      sfr_voice u_voice (
        .core_clk(core_clk),
        .rst_n(rst_s_n),
        .clr(chip_clr),
        .tick(tick),
        .src_ovf(vif[(gv + 2) % 3].ovf),
        .src_msb(vif[(gv + 2) % 3].msb),
        .vif(vif[gv])
      );
    end
  endgenerate
  assign wave3 = vif[2].wave;
  assign env3 = vif[2].env;

  // -----------------------------------------------------------------
  // filter controls and mixer
  // -----------------------------------------------------------------
  sfr_pkg::sfr_byte_t route, resp;
  sfr_pkg::sfr_byte_t dir_amp [0:3];
  sfr_pkg::sfr_byte_t flt_amp [0:3];
  sfr_pkg::sfr_byte_t src_amp [0:3];
  logic [9:0] dir_sum, flt_sum;
  logic [13:0] audio_reg;
  logic [9:0] filt_reg;

  assign route = rw_regs[`SFR_A_ROUTE];
  assign resp = rw_regs[`SFR_A_RESP];
  assign cutoff_value = {rw_regs[`SFR_A_CUT_HI], rw_regs[`SFR_A_CUT_LO][2:0]};
  assign peak_emphasis = route[7:4];
  assign lowpass_select = resp[4];
  assign bandpass_select = resp[5];
  assign upper_band_select = resp[6];
  assign master_level = resp[3:0];
  assign src_amp[0] = amp[0];
  assign src_amp[1] = amp[1];
  assign src_amp[2] = amp[2];
  assign src_amp[3] = ext_in;

  generate
    for (gv = 0; gv < 4; gv++)
    begin : g_route
      assign flt_amp[gv] = route[gv] ? src_amp[gv] : 8'h00;
      if (gv == 2)
      begin : g_v3
        assign dir_amp[gv] = (route[gv] || resp[`SFR_RB_V3_OFF]) ? 8'h00 : src_amp[gv];
      end
      else
      begin : g_vn
        assign dir_amp[gv] = route[gv] ? 8'h00 : src_amp[gv];
      end
    end
  endgenerate

  assign dir_sum = {2'h0, dir_amp[0]} + {2'h0, dir_amp[1]} + {2'h0, dir_amp[2]}
    + {2'h0, dir_amp[3]};
  assign flt_sum = {2'h0, flt_amp[0]} + {2'h0, flt_amp[1]} + {2'h0, flt_amp[2]}
    + {2'h0, flt_amp[3]};

  always_ff @(posedge core_clk or negedge rst_s_n)
    if (!rst_s_n)
    begin
      audio_reg <= 14'h0000;
      filt_reg <= 10'h000;
    end
    else
    begin
      audio_reg <= dir_sum * master_level;
      filt_reg <= flt_sum;
    end
  assign audio_direct = audio_reg;
  assign filter_input = filt_reg;

  // -----------------------------------------------------------------
  // paddle conversion
  // -----------------------------------------------------------------
  logic [8:0] phase_reg;
  logic pad_end;
  sfr_pkg::sfr_byte_t cnt_regs [0:1];

  assign pad_end = tick && (phase_reg == `SFR_PAD_LAST);
  // first half discharges the timing capacitor
  assign paddle_dump_out = 1'b0;
  assign paddle_dump_oe_n = phase_reg[8];

  always_ff @(posedge core_clk or negedge rst_s_n)
    if (!rst_s_n)
      phase_reg <= 9'h000;
    else if (tick)
      phase_reg <= phase_reg + 9'h001;

  generate
    for (gv = 0; gv < 2; gv++)
    begin : g_pad
      always_ff @(posedge core_clk or negedge rst_s_n)
        if (!rst_s_n)
        begin
          cnt_regs[gv] <= 8'h00;
          pad_regs[gv] <= 8'h00;
        end
        else if (tick)
        begin
          if (!phase_reg[8])
            cnt_regs[gv] <= 8'h00;
          else if (!pad_s[gv] && cnt_regs[gv] != `SFR_PAD_MAX)
            cnt_regs[gv] <= cnt_regs[gv] + 8'h01;
          if (pad_end)
            pad_regs[gv] <= cnt_regs[gv];
        end
    end
  endgenerate

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_s_n);

  write_store_a: assert property (
    wr_stb && !chip_clr && addr_p_reg == `SFR_A_CUT_HI
    |=> cutoff_value[10:3] == $past(data_p_reg))
    else $error("cutoff high write not stored");
  bus_gate_a: assert property (
    !data_oe_n |-> $past(pin_s1_reg[18]) && !$past(pin_s1_reg[17]))
    else $error("data driven outside read phase");
  unused_read_a: assert property (
    addr_s > `SFR_A_ENV3 |=> data_out == 8'h00)
    else $error("unused address read not zero");
  level_zero_a: assert property (
    master_level == 4'h0 |=> audio_direct == 14'h0000)
    else $error("zero level produced output");
  v3_cut_a: assert property (
    resp[`SFR_RB_V3_OFF] && !route[2] |-> dir_amp[2] == 8'h00 && flt_amp[2] == 8'h00)
    else $error("voice 3 reached output while cut");
  pad_hold_a: assert property (
    !pad_end |=> $stable(pad_regs[0]) && $stable(pad_regs[1]))
    else $error("paddle value changed mid conversion");
  pad_latch_a: assert property (
    pad_end |=> pad_regs[0] == $past(cnt_regs[0]))
    else $error("paddle value not latched at period end");
  chip_clear_a: assert property (
    chip_clr |=> cutoff_value == 11'h000 && master_level == 4'h0 ##1 audio_direct == 14'h0000)
    else $error("reset pin did not clear registers");
  osc3_read_a: assert property (
    addr_s == `SFR_A_OSC3 |=> data_out == $past(wave3[11:4]))
    else $error("oscillator readback mismatch");
  env3_read_a: assert property (
    addr_s == `SFR_A_ENV3 |=> data_out == $past(env3))
    else $error("envelope readback mismatch");

  write_seen_c: cover property (wr_stb && addr_p_reg == `SFR_A_RESP);
  osc3_read_c: cover property (rd_sel && addr_s == `SFR_A_OSC3);
  notch_mode_c: cover property (lowpass_select && upper_band_select && route[0]);
  pad_done_c: cover property (pad_end && pad_regs[0] != 8'h00);
endmodule : sfr_regs

// ==== sfr_voice.sv ====
// Purpose: one oscillator with envelope
// Assumes: tick is a one-cycle master clock enable
// Notes: neighbour oscillator drives phase lock and product modulation
`timescale 1ns/1ps
`include "sfr_cfg.svh"
module sfr_voice (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic tick,
  input wire logic src_ovf,
  input wire logic src_msb,
  sfr_voice_if.voice vif
);
  logic [23:0] acc_reg;
  logic [22:0] lfsr_reg;
  logic [15:0] div_reg;
  logic [11:0] wave_reg;
  sfr_pkg::sfr_byte_t env_reg;
  sfr_pkg::sfr_env_t st_reg;
  logic b19_reg;
  logic [24:0] sum;
  logic test, lock, gate, tri_msb, step, any;
  logic [11:0] tri_w, saw_w, pul_w, noi_w, mix_w;
  logic [3:0] rate;
  logic [15:0] base, period;
  logic [7:0] sus;

  assign sum = {1'b0, acc_reg} + {9'h000, vif.freq};
  assign test = vif.ctrl[`SFR_CB_TEST];
  assign gate = vif.ctrl[`SFR_CB_GATE];
  assign lock = vif.ctrl[`SFR_CB_SYNC] & src_ovf;
  assign vif.ovf = tick & ~acc_reg[23] & sum[23];
  assign vif.msb = acc_reg[23];
  assign tri_msb = vif.ctrl[`SFR_CB_RING] ? (acc_reg[23] ^ src_msb) : acc_reg[23];
  assign tri_w = {acc_reg[22:12] ^ {11{tri_msb}}, 1'b0};
  assign saw_w = acc_reg[23:12];
  assign pul_w = (acc_reg[23:12] >= vif.pw) ? 12'hFFF : 12'h000;
  assign noi_w = {lfsr_reg[22:18], lfsr_reg[14:8]};
  assign any = |vif.ctrl[`SFR_CB_NOI:`SFR_CB_TRI];
  // selected waveforms are ANDed
  assign mix_w = (vif.ctrl[`SFR_CB_TRI] ? tri_w : 12'hFFF)
    & (vif.ctrl[`SFR_CB_SAW] ? saw_w : 12'hFFF)
    & (vif.ctrl[`SFR_CB_PUL] ? pul_w : 12'hFFF)
    & (vif.ctrl[`SFR_CB_NOI] ? noi_w : 12'hFFF);
  assign vif.wave = wave_reg;
  assign vif.env = env_reg;
  assign rate = (st_reg == sfr_pkg::ENV_ATTACK) ? vif.ad[7:4]
    : (st_reg == sfr_pkg::ENV_DECAY) ? vif.ad[3:0] : vif.sr[3:0];
  assign base = ({12'h000, rate} + 16'h0001) << `SFR_ENV_SHIFT;
  assign period = (st_reg == sfr_pkg::ENV_ATTACK) ? base : base + (base << 1);
  assign step = tick && (div_reg >= period - 16'h0001);
  assign sus = {vif.sr[7:4], vif.sr[7:4]};

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      acc_reg <= 24'h000000;
      lfsr_reg <= 23'h000000;
      b19_reg <= 1'b0;
      wave_reg <= 12'h000;
    end
    else if (clr || (tick && (test || lock)))
    begin
      acc_reg <= 24'h000000;
      lfsr_reg <= 23'h000000;
      b19_reg <= 1'b0;
      wave_reg <= 12'h000;
    end
    else
    begin
      wave_reg <= any ? mix_w : 12'h000;
      if (tick)
      begin
        acc_reg <= sum[23:0];
        b19_reg <= acc_reg[19];
        if (acc_reg[19] && !b19_reg)
          lfsr_reg <= {lfsr_reg[21:0], ~(lfsr_reg[22] ^ lfsr_reg[17])};
      end
    end

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      div_reg <= 16'h0000;
    else if (clr || step)
      div_reg <= 16'h0000;
    else if (tick)
      div_reg <= div_reg + 16'h0001;

  // envelope ramps; gate changes act at once
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      st_reg <= sfr_pkg::ENV_RELEASE;
      env_reg <= 8'h00;
    end
    else if (clr)
    begin
      st_reg <= sfr_pkg::ENV_RELEASE;
      env_reg <= 8'h00;
    end
    else if (gate && st_reg == sfr_pkg::ENV_RELEASE)
      st_reg <= sfr_pkg::ENV_ATTACK;
    else if (!gate && st_reg != sfr_pkg::ENV_RELEASE)
      st_reg <= sfr_pkg::ENV_RELEASE;
    else if (step)
      case (st_reg)
        sfr_pkg::ENV_ATTACK:
          if (env_reg == 8'hFF)
            st_reg <= sfr_pkg::ENV_DECAY;
          else
            env_reg <= env_reg + 8'h01;
        sfr_pkg::ENV_DECAY:
          if (env_reg <= sus)
            st_reg <= sfr_pkg::ENV_SUSTAIN;
          else
            env_reg <= env_reg - 8'h01;
        sfr_pkg::ENV_SUSTAIN:
          if (env_reg > sus)
            st_reg <= sfr_pkg::ENV_DECAY;
        sfr_pkg::ENV_RELEASE:
          if (env_reg != 8'h00)
            env_reg <= env_reg - 8'h01;
        default:
          st_reg <= sfr_pkg::ENV_RELEASE;
      endcase

  phase_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    tick && lock && !clr |=> acc_reg == 24'h000000)
    else $error("phase lock did not restart oscillator");
  test_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    tick && test |=> acc_reg == 24'h000000)
    else $error("test bit did not hold oscillator");
endmodule : sfr_voice

// ==== sfr_voice_if.sv ====
// Purpose: register settings into a voice, waveform and envelope out
// Assumes: single core clock
// Notes: one instance per voice
`timescale 1ns/1ps
interface sfr_voice_if;
  logic [15:0] freq;
  logic [11:0] pw;
  sfr_pkg::sfr_byte_t ctrl;
  sfr_pkg::sfr_byte_t ad;
  sfr_pkg::sfr_byte_t sr;
  logic [11:0] wave;
  sfr_pkg::sfr_byte_t env;
  logic ovf;
  logic msb;
  modport regs (output freq, pw, ctrl, ad, sr, input wave, env, ovf, msb);
  modport voice (input freq, pw, ctrl, ad, sr, output wave, env, ovf, msb);
endinterface : sfr_voice_if

// ==== tb_synth_filter_and_readback_regs.sv ====
// Purpose: self-checking bench for the synth register block
// Assumes: 10 MHz core clock, host model on the register pins
// Notes: voices stay silent until the voice 3 scenario
`timescale 1ns/1ps
`include "sfr_cfg.svh"
module tb_synth_filter_and_readback_regs;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic chip_reset_n = 1'b1;
  logic [7:0] ext_in = 8'h00;
  logic bus_phase, cs_n, rw, data_oe_n, paddle_dump_out, paddle_dump_oe_n;
  logic paddle_x_in, paddle_y_in, lowpass_select, bandpass_select, upper_band_select;
  logic [4:0] addr;
  logic [7:0] host_data, data_out, data_in;
  logic [13:0] audio_direct;
  logic [9:0] filter_input;
  logic [10:0] cutoff_value;
  logic [3:0] peak_emphasis, master_level;
  int x_ticks = 100;
  int charge_cnt = 0;
  int err_total = 0;
  int check_count = 0;

  always #50 core_clk = ~core_clk;
  // capacitor charges while not dumped
  always @(negedge core_clk) charge_cnt <= paddle_dump_oe_n ? charge_cnt + 1 : 0;
  assign paddle_x_in = !paddle_dump_oe_n ? paddle_dump_out : charge_cnt >= x_ticks * 10;
  assign paddle_y_in = !paddle_dump_oe_n ? paddle_dump_out : charge_cnt >= 3000;
  assign data_in = data_oe_n ? host_data : data_out;

  sfr_host i_sfr_host (.core_clk(core_clk), .bus_phase(bus_phase), .cs_n(cs_n), .rw(rw),
    .addr(addr), .host_data(host_data), .data_out(data_out), .data_oe_n(data_oe_n));
  sfr_regs i_sfr_regs (.core_clk(core_clk), .rst_n(rst_n), .chip_reset_n(chip_reset_n),
    .bus_phase(bus_phase), .cs_n(cs_n), .rw(rw), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .paddle_x_in(paddle_x_in),
    .paddle_y_in(paddle_y_in), .paddle_dump_out(paddle_dump_out),
    .paddle_dump_oe_n(paddle_dump_oe_n), .ext_in(ext_in), .audio_direct(audio_direct),
    .filter_input(filter_input), .cutoff_value(cutoff_value),
    .peak_emphasis(peak_emphasis), .lowpass_select(lowpass_select),
    .bandpass_select(bandpass_select), .upper_band_select(upper_band_select),
    .master_level(master_level));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic test_done;
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_near(input logic [7:0] got, input int exp, input string what);
    check_count++;
    if ($isunknown(got) || int'(got) < exp - 2 || int'(got) > exp + 2)
    begin
      err_total++;
      $display("FAIL %0t %s got %h near %0d", $time, what, got, exp);
    end
  endtask : chk_near

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic o;
    i_sfr_host.cycle(a, d, 1'b0, 1'b0, q, o);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    logic o;
    i_sfr_host.cycle(a, 8'h00, 1'b1, 1'b0, q, o);
    chk({15'h0, o}, 16'h0000, "read drive");
  endtask : rd

  task automatic wait_dump(input logic lvl);
    for (int i = 0; paddle_dump_oe_n !== lvl; i++)
    begin
      if (i > 6000)
      begin
        err_total++;
        test_done;
      end
      @(negedge core_clk);
    end
  endtask : wait_dump

  task automatic watch(input int n, output logic a_nz, output logic f_nz);
    a_nz = 1'b0;
    f_nz = 1'b0;
    repeat (n)
    begin
      @(negedge core_clk);
      a_nz |= audio_direct != 14'h0;
      f_nz |= filter_input != 10'h0;
    end
  endtask : watch

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // cleared state
  task automatic t_reset;
    chk({5'h0, cutoff_value}, 16'h0000, "cutoff");
    chk({5'h0, peak_emphasis, master_level, lowpass_select, bandpass_select,
      upper_band_select}, 16'h0000, "mode");
    chk({2'h0, audio_direct}, 16'h0000, "audio");
    chk({15'h0, data_oe_n}, 16'h0001, "bus idle");
  endtask : t_reset

  task automatic t_cutoff;
    logic [7:0] q;
    logic o;
    wr(`SFR_A_CUT_LO, 8'hFF);
    wr(`SFR_A_CUT_HI, 8'hA5);
    chk({5'h0, cutoff_value}, 16'h052F, "cutoff join");
    wr(`SFR_A_CUT_LO, 8'hF8);
    chk({5'h0, cutoff_value}, 16'h0528, "cutoff low");
    i_sfr_host.cycle(`SFR_A_CUT_HI, 8'h11, 1'b0, 1'b1, q, o);
    chk({5'h0, cutoff_value}, 16'h0528, "deselected");
  endtask : t_cutoff

  task automatic t_route_level;
    wr(`SFR_A_ROUTE, 8'hF0);
    chk({12'h0, peak_emphasis}, 16'h000F, "emphasis");
    ext_in = 8'h80;
    wr(`SFR_A_RESP, 8'h0F);
    chk({2'h0, audio_direct}, 16'h0780, "level 15");
    chk({6'h0, filter_input}, 16'h0000, "unrouted");
    wr(`SFR_A_RESP, 8'h07);
    chk({2'h0, audio_direct}, 16'h0380, "level 7");
    wr(`SFR_A_ROUTE, 8'h08);
    chk({2'h0, audio_direct}, 16'h0000, "routed direct");
    chk({6'h0, filter_input}, 16'h0080, "routed");
    wr(`SFR_A_ROUTE, 8'h00);
    wr(`SFR_A_RESP, 8'h00);
    chk({2'h0, audio_direct}, 16'h0000, "level 0");
    ext_in = 8'h00;
  endtask : t_route_level

  task automatic t_modes;
    for (int m = 0; m < 8; m++)
    begin
      wr(`SFR_A_RESP, {1'b0, m[2:0], 4'h3});
      chk({13'h0, upper_band_select, bandpass_select, lowpass_select},
        {13'h0, m[2:0]}, "response");
      chk({12'h0, master_level}, 16'h0003, "level kept");
    end
  endtask : t_modes

  task automatic t_unmapped;
    logic [7:0] q;
    wr(5'h1D, 8'h5A);
    rd(5'h1D, q);
    chk({8'h0, q}, 16'h0000, "unused read");
    chk({5'h0, cutoff_value}, 16'h0528, "unused write");
    rd(`SFR_A_CUT_LO, q);
    chk({8'h0, q}, 16'h0000, "write-only read");
  endtask : t_unmapped

  task automatic t_paddles;
    logic [7:0] q;
    wr(`SFR_A_PADY, 8'h00);
    repeat (5300) @(negedge core_clk);
    rd(`SFR_A_PADY, q);
    chk({8'h0, q}, 16'h00FF, "paddle y max");
    wait_dump(1'b1);
    wait_dump(1'b0);
    x_ticks = 50;
    rd(`SFR_A_PADX, q);
    chk_near(q, 100, "paddle x held");
    wait_dump(1'b1);
    rd(`SFR_A_PADX, q);
    chk_near(q, 100, "paddle x mid");
    wait_dump(1'b0);
    rd(`SFR_A_PADX, q);
    chk_near(q, 50, "paddle x new");
  endtask : t_paddles

  task automatic t_voice3;
    logic [7:0] q, q2;
    logic a_nz, f_nz;
    wr(5'h0F, 8'hFF);
    wr(5'h12, 8'h20);
    rd(`SFR_A_OSC3, q);
    repeat (30) @(negedge core_clk);
    rd(`SFR_A_OSC3, q2);
    chk({15'h0, q2 != q}, 16'h0001, "osc runs");
    rd(`SFR_A_ENV3, q);
    chk({8'h0, q}, 16'h0000, "env ungated");
    wr(5'h14, 8'hF0);
    wr(5'h12, 8'h21);
    repeat (1000) @(negedge core_clk);
    rd(`SFR_A_ENV3, q);
    chk({15'h0, q != 8'h00}, 16'h0001, "env gated");
    wr(`SFR_A_RESP, 8'h0F);
    watch(3000, a_nz, f_nz);
    chk({14'h0, a_nz, f_nz}, 16'h0002, "voice 3 direct");
    wr(5'h08, 8'hFF);
    wr(5'h12, 8'h23);
    wr(`SFR_A_RESP, 8'h8F);
    wr(`SFR_A_ROUTE, 8'h04);
    watch(3000, a_nz, f_nz);
    chk({14'h0, a_nz, f_nz}, 16'h0001, "voice 3 off");
  endtask : t_voice3

  task automatic t_chip_reset;
    logic [7:0] q;
    chip_reset_n = 1'b0;
    repeat (110) @(negedge core_clk);
    chip_reset_n = 1'b1;
    repeat (6) @(negedge core_clk);
    t_reset;
    rd(`SFR_A_ENV3, q);
    chk({8'h0, q}, 16'h0000, "env cleared");
  endtask : t_chip_reset

  initial
  begin
    #4000000;
    err_total++;
    test_done;
  end

  initial
  begin
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    t_reset;
    t_cutoff;
    t_route_level;
    t_modes;
    t_unmapped;
    t_paddles;
    t_voice3;
    t_chip_reset;
    test_done;
  end
endmodule : tb_synth_filter_and_readback_regs
